// [include/lpd_link_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface lpd_link_if
    import lpd_pkg::*;
#(
    parameter int DQ_W = DQ_W_WIDE
);
    localparam int LANES = DQ_W / LANE_W;

    logic                clk_true;
    logic                clk_comp;
    logic                cke;
    logic                cs_n;
    logic [CA_W-1:0]     cmd_addr_bus;
    logic [LANES-1:0]    write_mask;
    logic [DQ_W-1:0]     ctl_dq_o;
    logic                ctl_dq_oe;
    logic [DQ_W-1:0]     dev_dq_o;
    logic                dev_dq_oe;
    logic [LANES-1:0]    ctl_dqs_t_o;
    logic [LANES-1:0]    ctl_dqs_c_o;
    logic                ctl_dqs_oe;
    logic [LANES-1:0]    dev_dqs_t_o;
    logic [LANES-1:0]    dev_dqs_c_o;
    logic                dev_dqs_oe;
    logic [DQ_W-1:0]     dq;
    logic [LANES-1:0]    dqs_t;
    logic [LANES-1:0]    dqs_c;

    // wire levels; an undriven bus reads as zero
    assign dq    = ctl_dq_oe ? ctl_dq_o : (dev_dq_oe ? dev_dq_o : '0);
    assign dqs_t = ctl_dqs_oe ? ctl_dqs_t_o : (dev_dqs_oe ? dev_dqs_t_o : '0);
    assign dqs_c = ctl_dqs_oe ? ctl_dqs_c_o : (dev_dqs_oe ? dev_dqs_c_o : '0);

    modport ctrl (
        output clk_true, clk_comp, cke, cs_n, cmd_addr_bus, write_mask,
        output ctl_dq_o, ctl_dq_oe, ctl_dqs_t_o, ctl_dqs_c_o, ctl_dqs_oe,
        input  dq, dqs_t, dqs_c
    );
    modport dev (
        input  clk_true, clk_comp, cke, cs_n, cmd_addr_bus, write_mask,
        output dev_dq_o, dev_dq_oe, dev_dqs_t_o, dev_dqs_c_o, dev_dqs_oe,
        input  dq, dqs_t, dqs_c
    );
endinterface // lpd_link_if
`default_nettype wire

// [include/lpd_pkg.sv]
`default_nettype none
package lpd_pkg;
    localparam int CA_W        = 10;
    localparam int LANE_W      = 8;
    localparam int DQ_W_NARROW = 16;
    localparam int DQ_W_WIDE   = 32;
    localparam int COL_W_DEF   = 4;

    localparam logic [1:0] OP_NOP   = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ  = 2'h2;

    // controller phases within one link clock (four core cycles)
    localparam logic [1:0] PH_ACCEPT   = 2'h0;
    localparam logic [1:0] PH_DQS_RISE = 2'h1;
    localparam logic [1:0] PH_RD_BEAT0 = 2'h1;
    localparam logic [1:0] PH_FALL_CA  = 2'h2;
    localparam logic [1:0] PH_BEAT1    = 2'h2;
    localparam logic [1:0] PH_LAST     = 2'h3;

    localparam logic CKE_RST  = 1'h0;
    localparam logic CS_N_RST = 1'h1;

    typedef enum logic [1:0] {C_IDLE, C_CMD, C_XFER, C_TAIL} lpd_ctl_state_type;

    function automatic logic [1:0] lpd_decode(input logic       cke,
                                              input logic       cs_n,
                                              input logic [1:0] op);
        lpd_decode = (cke && !cs_n && op != 2'h3) ? op : OP_NOP;
    endfunction
endpackage
`default_nettype wire

// [logic/lpd_ctl_end.sv]
`timescale 1ns/10ps
`default_nettype none
module lpd_ctl_end
    import lpd_pkg::*;
#(
    parameter int DQ_W  = DQ_W_WIDE,
    parameter int COL_W = COL_W_DEF
) (
    lpd_link_if.ctrl                    link,
    input  wire logic                   core_clk,
    input  wire logic                   rst,
    input  wire logic                   pd_req,
    input  wire logic                   req_valid,
    input  wire logic                   req_write,
    input  wire logic [COL_W-1:0]       req_col,
    input  wire logic [2*DQ_W-1:0]      req_wdata,
    input  wire logic [2*DQ_W/8-1:0]    req_wmask,
    output logic                        req_ready,
    output logic                        rsp_valid,
    output logic [2*DQ_W-1:0]           rsp_rdata,
    output logic                        pwr_save
);
    localparam int LANES = DQ_W / LANE_W;

    lpd_ctl_state_type      state_q;
    logic [1:0]             ph_q;
    logic [1:0]             ph_d;
    logic                   clk_q;
    logic                   clkc_q;
    logic                   cke_q;
    logic                   cs_n_q;
    logic                   pd_q;
    logic [CA_W-1:0]        ca_q;
    logic                   wr_q;
    logic [COL_W-1:0]       col_q;
    logic [2*DQ_W-1:0]      wdata_q;
    logic [2*LANES-1:0]     wmask_q;
    logic                   rdy_q;
    logic                   oe_q;
    logic [DQ_W-1:0]        dq_q;
    logic                   dqs_q;
    logic                   dqsc_q;
    logic [LANES-1:0]       wm_q;
    logic [DQ_W-1:0]        dq_s1_q;
    logic [DQ_W-1:0]        dq_s2_q;
    logic [2*DQ_W-1:0]      rdata_q;
    logic                   rsp_q;

    // ------------------------------------------------------------
    // link clock: core clock divided by four
    // ------------------------------------------------------------
    assign ph_d = ph_q + 2'h1;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ph_q   <= PH_ACCEPT;
            clk_q  <= 1'h0;
            clkc_q <= 1'h1;
        end else begin
            ph_q   <= ph_d;
            clk_q  <= ph_d[1];
            clkc_q <= !ph_d[1];
        end
    end

    // ------------------------------------------------------------
    // command sequencer
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_q <= C_IDLE;
            cke_q   <= CKE_RST;
            pd_q    <= 1'h1;
            cs_n_q  <= CS_N_RST;
            ca_q    <= '0;
            wr_q    <= 1'h0;
            col_q   <= '0;
            wdata_q <= '0;
            wmask_q <= '0;
        end else begin
            case (state_q)
                C_IDLE: begin
                    if (ph_q == PH_ACCEPT && req_valid && rdy_q) begin
                        state_q <= C_CMD;
                        cs_n_q  <= 1'h0;
                        ca_q    <= CA_W'(req_write ? OP_WRITE : OP_READ);
                        wr_q    <= req_write;
                        col_q   <= req_col;
                        wdata_q <= req_wdata;
                        wmask_q <= req_wmask;
                    end else if (ph_q == PH_ACCEPT) begin
                        cke_q <= !pd_req;
                        pd_q  <= pd_req;
                    end
                end
                C_CMD: begin
                    if (ph_q == PH_FALL_CA) begin
                        ca_q <= CA_W'(col_q);
                    end
                    if (ph_q == PH_LAST) begin
                        state_q <= C_XFER;
                    end
                end
                C_XFER: begin
                    if (ph_q == PH_ACCEPT) begin
                        cs_n_q <= 1'h1;
                    end
                    if (ph_q == PH_LAST) begin
                        state_q <= C_TAIL;
                    end
                end
                C_TAIL: begin
                    if (ph_q == PH_LAST) begin
                        state_q <= C_IDLE;
                    end
                end
                default: begin
                    state_q <= C_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rdy_q <= 1'h0;
        end else begin
            rdy_q <= (ph_q == PH_LAST) && cke_q && !pd_req
                     && (state_q == C_IDLE || state_q == C_TAIL);
        end
    end

    // ------------------------------------------------------------
    // write drive: data launched, strobe centred
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            oe_q   <= 1'h0;
            dq_q   <= '0;
            dqs_q  <= 1'h0;
            dqsc_q <= 1'h1;
            wm_q   <= '0;
        end else if (state_q == C_XFER && wr_q) begin
            case (ph_q)
                PH_ACCEPT: begin
                    oe_q <= 1'h1;
                    dq_q <= wdata_q[DQ_W-1:0];
                    wm_q <= wmask_q[LANES-1:0];
                end
                PH_DQS_RISE: begin
                    dqs_q  <= 1'h1;
                    dqsc_q <= 1'h0;
                end
                PH_BEAT1: begin
                    dq_q <= wdata_q[2*DQ_W-1:DQ_W];
                    wm_q <= wmask_q[2*LANES-1:LANES];
                end
                default: begin
                    dqs_q  <= 1'h0;
                    dqsc_q <= 1'h1;
                end
            endcase
        end else if (ph_q == PH_ACCEPT) begin
            oe_q <= 1'h0;
            wm_q <= '0;
        end
    end

    // ------------------------------------------------------------
    // read capture: synchronised data taken by phase
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            dq_s1_q <= '0;
            dq_s2_q <= '0;
        end else begin
            dq_s1_q <= link.dq;
            dq_s2_q <= dq_s1_q;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rdata_q <= '0;
            rsp_q   <= 1'h0;
        end else begin
            rsp_q <= 1'h0;
            if (state_q == C_TAIL && !wr_q && ph_q == PH_RD_BEAT0) begin
                rdata_q[DQ_W-1:0] <= dq_s2_q;
            end
            if (state_q == C_TAIL && !wr_q && ph_q == PH_LAST) begin
                rdata_q[2*DQ_W-1:DQ_W] <= dq_s2_q;
                rsp_q                  <= 1'h1;
            end
        end
    end

    assign link.clk_true     = clk_q;
    assign link.clk_comp     = clkc_q;
    assign link.cke          = cke_q;
    assign link.cs_n         = cs_n_q;
    assign link.cmd_addr_bus = ca_q;
    assign link.write_mask   = wm_q;
    assign link.ctl_dq_o     = dq_q;
    assign link.ctl_dq_oe    = oe_q;
    assign link.ctl_dqs_t_o  = {LANES{dqs_q}};
    assign link.ctl_dqs_c_o  = {LANES{dqsc_q}};
    assign link.ctl_dqs_oe   = oe_q;
    assign req_ready         = rdy_q;
    assign rsp_valid         = rsp_q;
    assign rsp_rdata         = rdata_q;
    assign pwr_save          = pd_q;
endmodule // lpd_ctl_end
`default_nettype wire

// [logic/lpd_mem_end.sv]
`timescale 1ns/10ps
`default_nettype none
module lpd_mem_end
    import lpd_pkg::*;
#(
    parameter int DQ_W  = DQ_W_WIDE,
    parameter int COL_W = COL_W_DEF
) (
    lpd_link_if.dev             link,
    input  wire logic           rst,
    output logic                cmd_stb,
    output logic [1:0]          cmd_op,
    output logic [COL_W-1:0]    cmd_col,
    output logic                pwr_save
);
    localparam int LANES = DQ_W / LANE_W;
    localparam int DEPTH = 2 ** COL_W;

    logic                   cke_q;
    logic                   cs_n_q;
    logic [CA_W-1:0]        ca_rise_q;
    logic                   pwr_save_q;
    logic [1:0]             op_n;
    logic [COL_W-1:0]       col_q;
    logic                   wr_arm_q;
    logic                   rd_pend_q;
    logic                   cmd_stb_q;
    logic [1:0]             cmd_op_q;
    logic [COL_W-1:0]       cmd_col_q;
    logic                   rise_oe_q;
    logic [DQ_W-1:0]        rise_dq_q;
    logic                   fall_oe_q;
    logic                   fall_dv_q;
    logic [DQ_W-1:0]        fall_dq_q;
    logic [DQ_W-1:0]        rd_even;
    logic [DQ_W-1:0]        rd_odd;

    // ------------------------------------------------------------
    // positive edge: single-rate pins and rising half of the bus
    // ------------------------------------------------------------
    always_ff @(posedge link.clk_true or posedge rst) begin
        if (rst) begin
            cke_q      <= CKE_RST;
            cs_n_q     <= CS_N_RST;
            pwr_save_q <= 1'h1;
        end else begin
            cke_q      <= link.cke;
            cs_n_q     <= link.cs_n;
            pwr_save_q <= !link.cke;
        end
    end

    always_ff @(posedge link.clk_true or posedge rst) begin
        if (rst) begin
            ca_rise_q <= '0;
        end else if (link.cke) begin
            ca_rise_q <= link.cmd_addr_bus;
        end
    end

    // ------------------------------------------------------------
    // negative edge: falling half of the bus and decode
    // ------------------------------------------------------------
    assign op_n = lpd_decode(cke_q, cs_n_q, ca_rise_q[1:0]);

    always_ff @(posedge link.clk_comp or posedge rst) begin
        if (rst) begin
            col_q     <= '0;
            rd_pend_q <= 1'h0;
        end else begin
            rd_pend_q <= (op_n == OP_READ);
            if (op_n != OP_NOP) begin
                // bus carries the whole column from bit zero upward
                col_q <= link.cmd_addr_bus[COL_W-1:0];
            end
        end
    end

    always_ff @(posedge link.clk_comp or posedge rst) begin
        if (rst) begin
            wr_arm_q <= 1'h0;
        end else if (op_n == OP_WRITE) begin
            wr_arm_q <= 1'h1;
        end else if (op_n == OP_READ || !cke_q) begin
            wr_arm_q <= 1'h0;
        end
    end

    always_ff @(posedge link.clk_comp or posedge rst) begin
        if (rst) begin
            cmd_stb_q <= 1'h0;
            cmd_op_q  <= OP_NOP;
            cmd_col_q <= '0;
        end else begin
            cmd_stb_q <= (op_n != OP_NOP);
            cmd_op_q  <= op_n;
            if (op_n != OP_NOP) begin
                cmd_col_q <= link.cmd_addr_bus[COL_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // write storage, one true strobe and mask bit per lane
    // ------------------------------------------------------------
    for (genvar l = 0; l < LANES; l++) begin : g_lane
        logic [LANE_W-1:0] even_q [DEPTH];
        logic [LANE_W-1:0] odd_q  [DEPTH];

        // beat on the rising strobe edge lands at even word
        always_ff @(posedge link.dqs_t[l]) begin
            if (wr_arm_q && cke_q && !link.write_mask[l]) begin
                even_q[col_q] <= link.dq[l*LANE_W +: LANE_W];
            end
        end

        // beat on the falling strobe edge lands at odd word
        always_ff @(negedge link.dqs_t[l]) begin
            if (wr_arm_q && cke_q && !link.write_mask[l]) begin
                odd_q[col_q] <= link.dq[l*LANE_W +: LANE_W];
            end
        end

        assign rd_even[l*LANE_W +: LANE_W] = even_q[col_q];
        assign rd_odd[l*LANE_W +: LANE_W]  = odd_q[col_q];
    end

    // ------------------------------------------------------------
    // read launch, beat 0 on rising edge, beat 1 on falling
    // ------------------------------------------------------------
    always_ff @(posedge link.clk_true or posedge rst) begin
        if (rst) begin
            rise_oe_q <= 1'h0;
            rise_dq_q <= '0;
        end else begin
            rise_oe_q <= rd_pend_q && link.cke;
            rise_dq_q <= rd_even;
        end
    end

    always_ff @(posedge link.clk_comp or posedge rst) begin
        if (rst) begin
            fall_oe_q <= 1'h0;
            fall_dv_q <= 1'h0;
            fall_dq_q <= '0;
        end else begin
            // strobe preamble starts on the decode edge
            fall_oe_q <= ((op_n == OP_READ) || rise_oe_q) && cke_q;
            fall_dv_q <= rise_oe_q && cke_q;
            fall_dq_q <= rd_odd;
        end
    end

    // ------------------------------------------------------------
    // pin drive: halves selected by clock level
    // ------------------------------------------------------------
    assign link.dev_dq_o    = link.clk_true ? rise_dq_q : fall_dq_q;
    assign link.dev_dq_oe   = link.clk_true ? rise_oe_q : fall_dv_q;
    assign link.dev_dqs_oe  = link.clk_true ? rise_oe_q : fall_oe_q;
    assign link.dev_dqs_t_o = {LANES{link.clk_true}};
    assign link.dev_dqs_c_o = ~{LANES{link.clk_true}};

    assign cmd_stb  = cmd_stb_q;
    assign cmd_op   = cmd_op_q;
    assign cmd_col  = cmd_col_q;
    assign pwr_save = pwr_save_q;
endmodule // lpd_mem_end
`default_nettype wire

// [verification/lpd_link_asserts.sv]
`timescale 1ns/10ps
`default_nettype none
module lpd_link_asserts
    import lpd_pkg::*;
#(
    parameter int DQ_W = DQ_W_WIDE
) (
    input wire logic                core_clk,
    input wire logic                rst,
    input wire logic                clk_true,
    input wire logic                clk_comp,
    input wire logic                cke,
    input wire logic                cs_n,
    input wire logic [CA_W-1:0]     cmd_addr_bus,
    input wire logic [DQ_W-1:0]     ctl_dq_o,
    input wire logic                ctl_dq_oe,
    input wire logic                dev_dq_oe,
    input wire logic [DQ_W/8-1:0]   ctl_dqs_t_o,
    input wire logic                ctl_dqs_oe,
    input wire logic                dev_dqs_oe,
    input wire logic [DQ_W-1:0]     dq,
    input wire logic [DQ_W/8-1:0]   dqs_t,
    input wire logic [DQ_W/8-1:0]   dqs_c
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    // ------
    // link wire checks
    // ------
    a_clk_pair_inv: assert property (clk_comp == !clk_true)
        else $error("clock pair not inverse");
    a_clk_half_len: assert property ($rose(clk_true) |=> clk_true ##1 !clk_true)
        else $error("link clock high phase not two cycles");
    a_ca_both_edges: assert property ($changed(cmd_addr_bus) |=> $changed(clk_true))
        else $error("ca change not ahead of a clock edge");
    a_sel_rise_only: assert property ($changed(cs_n) |=> $rose(clk_true))
        else $error("select change not ahead of rising edge");
    a_cke_rise_only: assert property ($changed(cke) |=> $rose(clk_true))
        else $error("enable change not ahead of rising edge");
    a_strobe_comp_inv: assert property ((ctl_dqs_oe || dev_dqs_oe) |-> dqs_c == ~dqs_t)
        else $error("strobe complement not inverse");
    a_one_bus_owner: assert property (
        !((ctl_dq_oe || ctl_dqs_oe) && (dev_dq_oe || dev_dqs_oe)))
        else $error("both ends drive data or strobe");
    a_drive_needs_cke: assert property ((dev_dq_oe || dev_dqs_oe) |-> cke)
        else $error("device drives with enable low");
    a_wr_strobe_mid: assert property (ctl_dqs_oe && $past(ctl_dqs_oe) && $changed(ctl_dqs_t_o)
        |-> $stable(ctl_dq_o))
        else $error("write strobe moved with write data");
    a_rd_strobe_edge: assert property (dev_dq_oe && $past(dev_dq_oe) && $changed(dq)
        |-> $changed(dqs_t))
        else $error("read data moved without strobe edge");

    c_write_burst: cover property ($rose(ctl_dqs_oe));
    c_read_burst: cover property ($rose(dev_dq_oe));
    c_power_down: cover property ($fell(cke));
endmodule // lpd_link_asserts
`default_nettype wire

// [verification/tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import lpd_pkg::*;
    ;
    logic        core_clk;
    logic        rst;
    logic        pd_req;
    logic        req_valid;
    logic        req_write;
    logic        req_ready;
    logic        rsp_valid;
    logic        ctl_pwr;
    logic        dev_pwr;
    logic        cmd_stb;
    logic [3:0]  req_col;
    logic [3:0]  cmd_col;
    logic [3:0]  last_col;
    logic [1:0]  cmd_op;
    logic [1:0]  last_op;
    logic [7:0]  req_wmask;
    logic [63:0] req_wdata;
    logic [63:0] rsp_rdata;
    int          miscompares = 0;
    int          total_checks = 0;
    int          ncmd = 0;

    lpd_link_if lpd_link_if_inst ();
    lpd_ctl_end #(.DQ_W(32), .COL_W(4)) lpd_ctl_end_inst (.link(lpd_link_if_inst.ctrl),
        .core_clk(core_clk), .rst(rst), .pd_req(pd_req), .req_valid(req_valid),
        .req_write(req_write), .req_col(req_col), .req_wdata(req_wdata),
        .req_wmask(req_wmask), .req_ready(req_ready), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .pwr_save(ctl_pwr));
    lpd_mem_end #(.DQ_W(32), .COL_W(4)) lpd_mem_end_inst (.link(lpd_link_if_inst.dev),
        .rst(rst), .cmd_stb(cmd_stb), .cmd_op(cmd_op), .cmd_col(cmd_col), .pwr_save(dev_pwr));
    lpd_link_asserts lpd_link_asserts_inst (.core_clk(core_clk), .rst(rst),
        .clk_true(lpd_link_if_inst.clk_true), .clk_comp(lpd_link_if_inst.clk_comp),
        .cke(lpd_link_if_inst.cke), .cs_n(lpd_link_if_inst.cs_n),
        .cmd_addr_bus(lpd_link_if_inst.cmd_addr_bus), .ctl_dq_o(lpd_link_if_inst.ctl_dq_o),
        .ctl_dq_oe(lpd_link_if_inst.ctl_dq_oe), .dev_dq_oe(lpd_link_if_inst.dev_dq_oe),
        .ctl_dqs_t_o(lpd_link_if_inst.ctl_dqs_t_o), .ctl_dqs_oe(lpd_link_if_inst.ctl_dqs_oe),
        .dev_dqs_oe(lpd_link_if_inst.dev_dqs_oe), .dq(lpd_link_if_inst.dq),
        .dqs_t(lpd_link_if_inst.dqs_t), .dqs_c(lpd_link_if_inst.dqs_c));

    // ------
    // helpers
    // ------
    // sampled mid link cycle, away from the strobe's own edge
    always @(posedge lpd_link_if_inst.clk_true) begin
        if (cmd_stb === 1'b1) begin
            last_op <= cmd_op;
            last_col <= cmd_col;
            ncmd <= ncmd + 1;
        end
    end

    function automatic logic [63:0] pat(input logic [3:0] c);
        pat = {16{c}} ^ 64'h0123456789ABCDEF;
    endfunction

    function automatic logic [63:0] merge(input logic [63:0] o, input logic [63:0] n,
                                          input logic [7:0] m);
        for (int l = 0; l < 8; l++) begin
            merge[8*l+:8] = m[l] ? o[8*l+:8] : n[8*l+:8];
        end
    endfunction

    task automatic check_data(input string what, input logic [63:0] exp, input logic [63:0] got);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_flag(input string what, input logic exp, input logic got);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic results();
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // entered at a rising edge, returns at a rising edge
    task automatic do_req(input logic w, input logic [3:0] col, input logic [63:0] wd,
                          input logic [7:0] wm, output logic [63:0] rd);
        int n;
        int c0;
        c0 = ncmd;
        req_write <= w;
        req_col <= col;
        req_wdata <= wd;
        req_wmask <= wm;
        req_valid <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (req_ready !== 1'b1 && n < 64);
        req_valid <= 1'b0;
        check_flag("req taken", 1'b1, req_ready);
        rd = '0;
        if (!w) begin
            n = 0;
            do begin
                @(negedge core_clk);
                n++;
            end while (rsp_valid !== 1'b1 && n < 40);
            check_data("read latency", 64'h0C, 64'(n));
            rd = rsp_rdata;
        end
        repeat (12) @(posedge core_clk);
        check_data("cmd count", 64'(c0 + 1), 64'(ncmd));
        check_data("cmd op", w ? 64'h1 : 64'h2, 64'(last_op));
        check_data("cmd col", 64'(col), 64'(last_col));
    endtask

    // ------
    // scenarios
    // ------
    task automatic t_write_read();
        logic [63:0] rd;
        for (int c = 0; c < 16; c++) begin
            do_req(1'b1, 4'(c), pat(4'(c)), 8'h00, rd);
        end
        for (int c = 0; c < 16; c++) begin
            do_req(1'b0, 4'(c), '0, 8'h00, rd);
            check_data("read data", pat(4'(c)), rd);
        end
        $display("test write_read done");
    endtask

    task automatic t_mask();
        logic [63:0] rd;
        logic [63:0] old;
        logic [7:0]  masks [2];
        masks = '{8'h96, 8'hF0};
        old = pat(4'h2);
        for (int i = 0; i < 2; i++) begin
            do_req(1'b1, 4'h2, 64'hFEDCBA9876543210 ^ 64'(i), masks[i], rd);
            do_req(1'b0, 4'h2, '0, 8'h00, rd);
            old = merge(old, 64'hFEDCBA9876543210 ^ 64'(i), masks[i]);
            check_data("masked data", old, rd);
        end
        $display("test mask done");
    endtask

    task automatic t_power();
        logic [63:0] rd;
        int          n;
        int          c0;
        logic        taken;
        pd_req <= 1'b1;
        n = 0;
        while (ctl_pwr !== 1'b1 && n < 32) begin
            @(posedge core_clk);
            n++;
        end
        check_flag("ctl pwr_save", 1'b1, ctl_pwr);
        repeat (8) @(posedge core_clk);
        check_flag("dev pwr_save", 1'b1, dev_pwr);
        check_flag("cke", 1'b0, lpd_link_if_inst.cke);
        c0 = ncmd;
        taken = 1'b0;
        req_valid <= 1'b1;
        repeat (24) begin
            @(posedge core_clk);
            if (req_ready === 1'b1) taken = 1'b1;
        end
        req_valid <= 1'b0;
        check_flag("refused", 1'b0, taken);
        check_data("idle cmd count", 64'(c0), 64'(ncmd));
        @(posedge core_clk);
        pd_req <= 1'b0;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (ctl_pwr !== 1'b0 && n < 32);
        repeat (8) @(posedge core_clk);
        check_flag("dev wake", 1'b0, dev_pwr);
        do_req(1'b0, 4'h0, '0, 8'h00, rd);
        check_data("read after wake", pat(4'h0), rd);
        $display("test power done");
    endtask

    // ------
    // run control
    // ------
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    initial begin
        rst = 1'b1;
        pd_req = 1'b0;
        req_valid = 1'b0;
        req_write = 1'b0;
        req_col = '0;
        req_wdata = '0;
        req_wmask = '0;
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        repeat (2) @(posedge core_clk);
        t_write_read();
        t_mask();
        t_power();
        results();
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        miscompares++;
        results();
    end
endmodule // tb_top
`default_nettype wire
